// [core/pis_input_select.sv]
// Summary of operation
// - uart2 receive follows low byte of register 0
// - spi2 clock follows upper byte of register 1
// - spi2 data follows low byte of register 1
// - spi2 select follows low byte of register 2
// - can receive follows low byte of register 3
// - pwm sync one follows upper byte, register 4
// - deadtime input one follows register 5 upper byte
// - deadtime input three follows register 6 upper byte
// - deadtime input two follows register 6 low byte
// - sent input one follows register 7 upper byte
// - code b5 selects the last remappable input pin
// - code 01 selects comparator one output
// - code 00 ties the input low
// - unimplemented bits read zero, ignore writes
// - all selector bits clear at reset
// - selector bits read back last written value
`timescale 1ns/1ns
module pis_input_select (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pis_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pis_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pis_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pis_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [pis_pkg::PIN_N-1:0] remappable_pin,
  input wire logic remappable_input_pin_last,
  input wire logic comparator_one_output,
  output pis_pkg::pis_periph_t periph_in
);

  // ==========================================================
  // helpers
  function automatic logic [pis_pkg::IDX_W:0] decode_addr(
    input logic [pis_pkg::ADDR_W-1:0] addr
  );
    logic hit;
    hit = (addr >> (pis_pkg::IDX_LSB + pis_pkg::IDX_W)) == '0;
    return {hit, addr[pis_pkg::IDX_LSB +: pis_pkg::IDX_W]};
  endfunction

  function automatic logic pick_source(
    input logic [7:0] code,
    input logic [pis_pkg::PIN_N-1:0] pins,
    input logic last_pin,
    input logic cmp
  );
    logic r;
    r = 1'b0;
    if (code == pis_pkg::CODE_PIN_LAST)
    begin
      r = last_pin;
    end
    else if (code == pis_pkg::CODE_COMPARATOR_ONE)
    begin
      r = cmp;
    end
    else if (code >= pis_pkg::CODE_FIRST_PIN &&
             code < pis_pkg::CODE_PIN_LAST)
    begin
      r = pins[code];
    end
    return r;
  endfunction

  // ==========================================================
  // input synchronisers
  logic [pis_pkg::PIN_N+1:0] pin_meta_r;
  logic [pis_pkg::PIN_N+1:0] pin_sync_r;
  wire [pis_pkg::PIN_N+1:0] pin_raw =
    {comparator_one_output, remappable_input_pin_last, remappable_pin};
  wire [pis_pkg::PIN_N-1:0] pins_s = pin_sync_r[pis_pkg::PIN_N-1:0];
  wire last_s = pin_sync_r[pis_pkg::PIN_N];
  wire cmp_s = pin_sync_r[pis_pkg::PIN_N+1];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ==========================================================
  // write channel
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic aw_full_r;
  logic w_full_r;
  logic [pis_pkg::ADDR_W-1:0] awaddr_r;
  logic [pis_pkg::DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;

  wire aw_take = s_axi_awvalid & awready_r;
  wire w_take = s_axi_wvalid & wready_r;
  wire do_write = aw_full_r & w_full_r & ~bvalid_r;
  wire aw_full_nxt = (aw_full_r | aw_take) & ~do_write;
  wire w_full_nxt = (w_full_r | w_take) & ~do_write;
  wire [pis_pkg::IDX_W:0] wdec = decode_addr(awaddr_r);
  wire w_hit = wdec[pis_pkg::IDX_W];
  wire [pis_pkg::IDX_W-1:0] w_idx = wdec[pis_pkg::IDX_W-1:0];
  wire [pis_pkg::SEL_W-1:0] strobe_mask =
    {{pis_pkg::BYTE_W{wstrb_r[1]}}, {pis_pkg::BYTE_W{wstrb_r[0]}}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= pis_pkg::RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else
    begin
      awready_r <= ~aw_full_nxt;
      wready_r <= ~w_full_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      if (aw_take)
      begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= w_hit ? pis_pkg::RESP_OKAY : pis_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // selector registers
  logic [pis_pkg::SEL_W-1:0] sel_r [pis_pkg::REG_N];

  genvar g;
  generate
    for (g = 0; g < pis_pkg::REG_N; g++)
    begin : gen_sel
      wire [pis_pkg::SEL_W-1:0] wm =
        strobe_mask & pis_pkg::IMPL_MASK[g];
      wire wr_en = do_write & w_hit & (w_idx == pis_pkg::IDX_W'(g));
      wire [pis_pkg::SEL_W-1:0] sel_nxt =
        (sel_r[g] & ~wm) | (wdata_r[pis_pkg::SEL_W-1:0] & wm);

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sel_r[g] <= pis_pkg::SEL_RESET;
        end
        else if (wr_en)
        begin
          sel_r[g] <= sel_nxt;
        end
      end
    end
  endgenerate

  // ==========================================================
  // read channel
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [pis_pkg::DATA_W-1:0] rdata_r;

  wire ar_take = s_axi_arvalid & arready_r;
  wire [pis_pkg::IDX_W:0] rdec = decode_addr(s_axi_araddr);
  wire r_hit = rdec[pis_pkg::IDX_W];
  wire [pis_pkg::IDX_W-1:0] r_idx = rdec[pis_pkg::IDX_W-1:0];
  wire [pis_pkg::DATA_W-1:0] rdata_nxt =
    r_hit ? {{(pis_pkg::DATA_W-pis_pkg::SEL_W){1'b0}}, sel_r[r_idx]}
          : '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= pis_pkg::RESP_OKAY;
      rdata_r <= '0;
    end
    else if (ar_take)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rdata_nxt;
      rresp_r <= r_hit ? pis_pkg::RESP_OKAY : pis_pkg::RESP_SLVERR;
    end
    else if (rvalid_r)
    begin
      if (s_axi_rready)
      begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
    else
    begin
      arready_r <= 1'b1;
    end
  end

  // ==========================================================
  // routing
  logic [pis_pkg::PERIPH_N-1:0] route_nxt;
  pis_pkg::pis_periph_t periph_r;

  generate
    for (g = 0; g < pis_pkg::PERIPH_N; g++)
    begin : gen_route
      wire [pis_pkg::SEL_W-1:0] reg_val = sel_r[pis_pkg::FIELD_REG[g]];
      wire [7:0] code = pis_pkg::FIELD_HIGH[g] ?
        reg_val[pis_pkg::BYTE_W +: pis_pkg::BYTE_W] :
        reg_val[0 +: pis_pkg::BYTE_W];
      // fields 0..9
      assign route_nxt[g] =
        pick_source(code, pins_s, last_s, cmp_s);
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      periph_r <= '0;
    end
    else
    begin
      periph_r <= pis_pkg::pis_periph_t'(route_nxt);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign periph_in = periph_r;

endmodule

// [core/pis_pkg.sv]
package pis_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 16;
  localparam int REG_N = 8;
  localparam int IDX_W = 3;
  localparam int IDX_LSB = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // register byte addresses
  localparam logic [ADDR_W-1:0] UART2_RECEIVE_INPUT_SELECT_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] SPI2_CLOCK_DATA_INPUT_SELECT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] SPI2_SELECT_INPUT_SELECT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CAN_RECEIVE_INPUT_SELECT_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] PWM_SYNC_INPUT_SELECT_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] DEADTIME_COMP_ONE_SELECT_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] DEADTIME_COMP_TWO_THREE_SELECT_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] SENT_INPUT_ONE_SELECT_OFS = 8'h1c;

  // ==========================================================
  // implemented bits per register, all reset to zero
  localparam logic [SEL_W-1:0] SEL_RESET = 16'h0000;
  localparam logic [SEL_W-1:0] IMPL_MASK [REG_N] = '{
    16'h00ff, 16'hffff, 16'h00ff, 16'h00ff,
    16'hff00, 16'hff00, 16'hffff, 16'hff00};

  // ==========================================================
  // selector codes
  localparam logic [7:0] CODE_GROUND = 8'h00;
  localparam logic [7:0] CODE_COMPARATOR_ONE = 8'h01;
  localparam logic [7:0] CODE_FIRST_PIN = 8'h02;
  localparam logic [7:0] CODE_PIN_LAST = 8'hb5;
  localparam int PIN_N = 181;

  // ==========================================================
  // routed peripheral inputs: field i lives in register FIELD_REG[i],
  // upper byte when FIELD_HIGH[i] is set
  localparam int PERIPH_N = 10;
  localparam logic [IDX_W-1:0] FIELD_REG [PERIPH_N] = '{
    3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6, 3'h7};
  localparam logic [PERIPH_N-1:0] FIELD_HIGH = 10'h2e2;
  localparam int BYTE_W = 8;

  typedef struct packed {
    logic sent_one_input;
    logic deadtime_comp_two_input;
    logic deadtime_comp_three_input;
    logic deadtime_comp_one_input;
    logic pwm_sync_one_input;
    logic can_receive_input;
    logic spi2_slave_select_input;
    logic spi2_data_input;
    logic spi2_clock_input;
    logic uart2_receive_input;
  } pis_periph_t;

endpackage

// [tb/pis_pin_model.sv]
`timescale 1ns/1ns
// ==========================================================
// pads and comparator: levels change just after a clock edge
module pis_pin_model (
  input wire logic aclk,
  input wire logic [182:0] lvl,
  output logic [180:0] pins,
  output logic last,
  output logic cmp
);
  always_ff @(posedge aclk)
  begin
    {cmp, last, pins} <= lvl;
  end
endmodule

// [tb/pis_input_select_assertions.sv]
`timescale 1ns/1ns
module pis_input_select_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pis_pkg::pis_periph_t periph_in
);
  // ==========================================================
  // address of the read under way
  logic [7:0] a_r;
  wire ok = a_r[7:5] == 3'h0;
  wire [15:0] m = pis_pkg::IMPL_MASK[a_r[4:2]];
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      a_r <= s_axi_araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst; $rose(aresetn) |-> periph_in == '0; endproperty
  a_rst: assert property (p_rst) else $error("periph not low");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read late");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rdata moved");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bresp moved");
  property p_blat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("no bvalid");
  property p_unimp;
    s_axi_rvalid && ok |-> (s_axi_rdata & ~{16'h0, m}) == 32'h0;
  endproperty
  a_unimp: assert property (p_unimp) else $error("bits set");
  property p_bad;
    s_axi_rvalid && !ok |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_bad: assert property (p_bad) else $error("unmapped read");
  property p_okr; s_axi_rvalid && ok |-> s_axi_rresp == 2'h0; endproperty
  a_okr: assert property (p_okr) else $error("bad rresp");
  c_bad: cover property (s_axi_rvalid && !ok);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rt: cover property (periph_in != '0);
endmodule
bind pis_input_select pis_input_select_chk u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .periph_in);

// [tb/tb_peripheral_input_select.sv]
`timescale 1ns/1ns
module tb_peripheral_input_select;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 0, araddr = 0, c;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  logic [182:0] lvl = 0;
  logic [191:0] r;
  logic [180:0] pins;
  logic last, cmp;
  pis_pkg::pis_periph_t pin_o;
  int errors = 0, cmp_count = 0, seed = 32'hd7c30f54;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  pis_pin_model pm (.aclk, .lvl, .pins, .last, .cmp);
  pis_input_select dut (.aclk, .aresetn, .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .remappable_pin(pins), .remappable_input_pin_last(last),
    .comparator_one_output(cmp), .periph_in(pin_o));
  always #10 aclk = ~aclk;
  // ==========================================================
  // checking
  task chk(logic [33:0] g, logic [33:0] e, string s);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("Error at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask
  function logic ex(logic [7:0] k);
    if (k == 8'h01) return lvl[182];
    if (k == 8'hb5) return lvl[181];
    if (k > 8'h01 && k < 8'hb5) return lvl[k];
    return 1'b0;
  endfunction
  always @(negedge aclk)
  begin
    if (rvalid && rready)
      chk({rresp, rdata}, rq.pop_front(), "read");
    if (bvalid && bready)
      chk({32'h0, bresp}, {32'h0, bq.pop_front()}, "b");
  end
  task close_out;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // bus master
  task wr(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    logic ta, tw;
    bq.push_back(e);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
    repeat (40)
    begin
      @(negedge aclk);
      ta = awvalid && awready; tw = wvalid && wready;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if ((ta || !awvalid) && (tw || !wvalid)) break;
    end
    bready <= 1;
    repeat (40) begin @(negedge aclk); if (bvalid) break; end
    @(posedge aclk);
    bready <= 0;
  endtask
  task rd(logic [7:0] a, logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a; arvalid <= 1;
    repeat (40) begin @(negedge aclk); if (arready) break; end
    @(posedge aclk);
    arvalid <= 0; rready <= 1;
    repeat (40) begin @(negedge aclk); if (rvalid) break; end
    @(posedge aclk);
    rready <= 0;
  endtask
  // ==========================================================
  // tests
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 34'h0);
    chk({24'h0, pin_o}, 34'h0, "reset route");
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      wr(8'(i * 4), 32'hffffffff, 2'h0);
      rd(8'(i * 4), {18'h0, pis_pkg::IMPL_MASK[i]});
    end
    $display("readback test done");
    for (int i = 0; i < 10; i++)
      for (int k = 0; k < 5; k++)
      begin
        r = {$random(seed), $random(seed), $random(seed),
          $random(seed), $random(seed), $random(seed)};
        c = k == 0 ? 8'h00 : k == 1 ? 8'h01 : k == 2 ? 8'hb5 :
          k == 3 ? 8'h02 + 8'($unsigned($random(seed)) % 179) :
          8'hb6 + 8'($unsigned($random(seed)) % 74);
        @(posedge aclk);
        lvl <= k == 0 ? '1 : r[182:0];
        wr({3'h0, pis_pkg::FIELD_REG[i], 2'h0}, {16'h0, c, c}, 2'h0);
        repeat (4) @(negedge aclk);
        chk({33'h0, pin_o[i]}, {33'h0, ex(c)}, "route");
      end
    $display("routing test done");
    wr(8'h00, 32'h12, 2'h0);
    wr(8'h20, 32'hffff, 2'h2);
    rd(8'h20, {2'h2, 32'h0});
    rd(8'h00, {2'h0, 32'h12});
    $display("unmapped test done");
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00, 34'h0);
    chk({24'h0, pin_o}, 34'h0, "reset route 2");
    $display("second reset test done");
    close_out;
  end
  initial
  begin
    #400000;
    errors++;
    close_out;
  end
endmodule
